// ==== logic/rcl_pkg.sv ====
// constants for the reset configuration latch array
package rcl_pkg;
   // register offsets (latch byte index)
   localparam logic [1:0] ADDR_PORT_LOW   = 2'h0;
   localparam logic [1:0] ADDR_PORT_HIGH  = 2'h1;
   localparam logic [1:0] ADDR_PIN_DEBUG  = 2'h2;
   localparam logic [1:0] ADDR_BOOT_CFG   = 2'h3;
   localparam int         NUM_BYTES       = 4;
   localparam int         ADDR_W          = 2;
   // factory values of each latch byte
   localparam logic [7:0] RST_PORT_LOW    = 8'h00;
   localparam logic [7:0] RST_PORT_HIGH   = 8'h00;
   localparam logic [7:0] RST_PIN_DEBUG   = 8'h40;
   localparam logic [7:0] RST_BOOT_CFG    = 8'h0A;
   // field positions
   localparam int         POS_PORT15_LO   = 0;
   localparam int         POS_DEBUG_EN    = 6;
   localparam int         POS_EXT_RESET   = 7;
   localparam int         POS_BOOT_SPEED  = 0;
   localparam int         POS_DBG_PORT_LO = 1;
   localparam int         POS_ECC_EN      = 3;
   localparam int         POS_PHASE_LO    = 4;
   localparam int         NUM_PORTS       = 9;
   // writable bits of byte 2; the other bits always read zero
   localparam logic [7:0] MASK_PIN_DEBUG  = 8'hC3;
   // drive mode encodings
   typedef enum logic [1:0] {
      DRV_ANALOG_HIZ  = 2'b00,
      DRV_DIGITAL_HIZ = 2'b01,
      DRV_PULL_UP     = 2'b10,
      DRV_PULL_DOWN   = 2'b11
   } rcl_drive_e;
   // debug port encodings
   typedef enum logic [1:0] {
      DBG_JTAG5 = 2'b00,
      DBG_JTAG4 = 2'b01,
      DBG_SWD   = 2'b10,
      DBG_OFF   = 2'b11
   } rcl_dbgport_e;
   // capture sequencer states, gray along the path
   typedef enum logic [1:0] {
      ST_RESET   = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_RUN     = 2'b11
   } rcl_state_e;
endpackage

// ==== logic/rcl_latch_byte.sv ====
// one byte of the nonvolatile latch array with its factory value
`timescale 1ns/1ps
`default_nettype none
module rcl_latch_byte #(
   parameter logic [7:0] FACTORY = 8'h00,
   parameter logic [7:0] MASK    = 8'hFF
) (
   // clock; the stored byte ignores reset by nature
   input  wire logic       clk,
   // update port
   input  wire logic       writeEn,
   input  wire logic [7:0] writeData,
   // stored value
   output logic      [7:0] value
);
   // nonvolatile: reset does not disturb the stored byte, only power-up
   // takes the factory value, modelled by the declared initial value
   logic [7:0] store_reg = FACTORY;
   logic [7:0] store_next;

   // next value; reserved bits are forced to zero
   always_comb begin
      store_next = store_reg;
      if (writeEn) begin
         store_next = writeData & MASK;
      end
   end

   always_ff @(posedge clk) begin
      store_reg <= store_next;
   end

   assign value = store_reg;
endmodule
`default_nettype wire

// ==== logic/rcl_reset_config_latch.sv ====
// nonvolatile reset configuration latches with captured device settings
//
// Summary of operation
// - four latch bytes configure device at reset
// - two-bit field selects port reset drive
// - one drive setting covers whole port
// - reset pin select: GPIO or reset
// - debug enable bit gates debug access
// - boot clock bit picks 12/48 MHz
// - debug port select: JTAG5, JTAG4, SWD, off
// - ECC enable reserves spare flash region
// - top nibble of byte 3: phase delay
// - byte layout of ports and bits
`timescale 1ns/1ps
`default_nettype none
module rcl_reset_config_latch #(
   parameter int NPORTS = rcl_pkg::NUM_PORTS
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rstn,
   // register port
   input  wire logic [rcl_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [7:0]                   regWdata,
   input  wire logic                         regWrite,
   input  wire logic                         regRead,
   output logic      [7:0]                   regRdata,
   // port reset drive modes: 0..6, 12, 15
   output logic      [2*NPORTS-1:0]          portResetDriveMode,
   // reset, debug, clock and flash settings
   output logic                              extResetPinSelect,
   output logic                              debugAccessEnable,
   output logic      [1:0]                   debugPortSelect,
   output logic                              bootClockSpeed,
   output logic                              eccRegionEnable,
   output logic      [3:0]                   digitalClockPhaseDelay,
   // high once settings have been captured
   output logic                              configValid
);
   import rcl_pkg::*;

   // elaboration guard: the field layout is fixed to this port count
   if (NPORTS != NUM_PORTS) begin : g_bad_nports
      $error("port count must match latch layout");
   end

   localparam logic [7:0] FACTORY [NUM_BYTES] =
      '{RST_PORT_LOW, RST_PORT_HIGH, RST_PIN_DEBUG, RST_BOOT_CFG};

   logic [7:0] latchVal [NUM_BYTES];
   logic [7:0] shadow_reg [NUM_BYTES];
   logic [7:0] shadow_next [NUM_BYTES];
   rcl_state_e state_reg;
   rcl_state_e state_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       valid_reg;
   logic       valid_next;

   // each write costs one latch cycle, no write-back on reset
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BYTES; gi++) begin : g_byte
         rcl_latch_byte #(
            .FACTORY (FACTORY[gi]),
            .MASK    (gi == int'(ADDR_PIN_DEBUG) ? MASK_PIN_DEBUG : 8'hFF)
         ) u_byte (
            .clk       (clk),
            .writeEn   (regWrite && regAddr == ADDR_W'(gi)),
            .writeData (regWdata),
            .value     (latchVal[gi])
         );
      end
   endgenerate

   // capture sequencer: hold in reset, capture on release, then run
   always_comb begin
      state_next = state_reg;
      valid_next = valid_reg;
      for (int i = 0; i < NUM_BYTES; i++) begin
         shadow_next[i] = shadow_reg[i];
      end
      case (state_reg)
         ST_RESET: begin
            state_next = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            for (int i = 0; i < NUM_BYTES; i++) begin
               shadow_next[i] = latchVal[i];
            end
            valid_next = 1'b1;
            state_next = ST_RUN;
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg <= ST_RESET;
         valid_reg <= 1'b0;
         for (int i = 0; i < NUM_BYTES; i++) begin
            shadow_reg[i] <= FACTORY[i];
         end
      end else begin
         state_reg <= state_next;
         valid_reg <= valid_next;
         for (int i = 0; i < NUM_BYTES; i++) begin
            shadow_reg[i] <= shadow_next[i];
         end
      end
   end

   // read path shows stored latch bytes, not the captured copy
   always_comb begin
      rdata_next = 8'h00;
      if (regRead) begin
         rdata_next = latchVal[regAddr];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign regRdata    = rdata_reg;
   assign configValid = valid_reg;

   // drive mode encoding passes through unchanged
   // one field per port, fanned to all its pins outside
   assign portResetDriveMode = {
      shadow_reg[ADDR_PIN_DEBUG][POS_PORT15_LO +: 2],
      shadow_reg[ADDR_PORT_HIGH],
      shadow_reg[ADDR_PORT_LOW]
   };

   assign extResetPinSelect = shadow_reg[ADDR_PIN_DEBUG][POS_EXT_RESET];
   assign debugAccessEnable = shadow_reg[ADDR_PIN_DEBUG][POS_DEBUG_EN];
   assign debugPortSelect = shadow_reg[ADDR_BOOT_CFG][POS_DBG_PORT_LO +: 2];
   // boot clock 12 or 48 MHz
   assign bootClockSpeed = shadow_reg[ADDR_BOOT_CFG][POS_BOOT_SPEED];
   assign eccRegionEnable = shadow_reg[ADDR_BOOT_CFG][POS_ECC_EN];
   assign digitalClockPhaseDelay = shadow_reg[ADDR_BOOT_CFG][POS_PHASE_LO +: 4];
endmodule
`default_nettype wire

// ==== sim/rcl_reset_config_latch_assertions.sv ====
// port checker of the reset configuration latch array
`timescale 1ns/1ps
`default_nettype none
module rcl_reset_config_latch_checker #(parameter int NPORTS = 9) (
   // clock, reset and register port
   input wire logic                clk, rstn, regWrite, regRead,
   input wire logic [1:0]          regAddr,
   input wire logic [7:0]          regWdata, regRdata,
   // captured settings
   input wire logic [2*NPORTS-1:0] portResetDriveMode,
   input wire logic                extResetPinSelect, debugAccessEnable, bootClockSpeed,
   input wire logic                eccRegionEnable, configValid,
   input wire logic [1:0]          debugPortSelect,
   input wire logic [3:0]          digitalClockPhaseDelay
);
   // all settings in one vector, laid out as the bench packs them
   wire logic [2*NPORTS+9:0] cfg = {portResetDriveMode, extResetPinSelect, debugAccessEnable,
      debugPortSelect, bootClockSpeed, eccRegionEnable, digitalClockPhaseDelay};
   default clocking @(posedge clk); endclocking
   property p_factory; !rstn |=> cfg == 28'h000_0150 && !configValid && regRdata == 8'h00;
   endproperty
   a_factory: assert property (p_factory) else $error("factory values missing");
   property p_phase; !rstn |=> digitalClockPhaseDelay == 4'h0; endproperty
   a_phase: assert property (p_phase) else $error("phase delay not zero");
   property p_valid; disable iff (!rstn) $rose(rstn) |=> !configValid ##1 configValid;
   endproperty
   a_valid: assert property (p_valid) else $error("capture timing wrong");
   property p_stable; disable iff (!rstn) configValid |=> $stable(cfg); endproperty
   a_stable: assert property (p_stable) else $error("settings moved");
   property p_hold; disable iff (!rstn) configValid |=> configValid; endproperty
   a_hold: assert property (p_hold) else $error("valid dropped");
   property p_wrRd; disable iff (!rstn) regWrite ##1 (regRead && regAddr == $past(regAddr))
      |=> regRdata == ($past(regWdata, 2) & ($past(regAddr) == 2'h2 ? 8'hC3 : 8'hFF));
   endproperty
   a_wrRd: assert property (p_wrRd) else $error("readback differs");
   property p_byte2; disable iff (!rstn) regRead && regAddr == 2'h2 |=> regRdata[5:2] == 4'h0;
   endproperty
   a_byte2: assert property (p_byte2) else $error("reserved bits set");
   property p_idle; disable iff (!rstn) !regRead |=> regRdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data lingers");
endmodule
bind rcl_reset_config_latch rcl_reset_config_latch_checker #(.NPORTS(NPORTS)) chk (
   .clk(clk), .rstn(rstn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
   .regWdata(regWdata), .regRdata(regRdata), .portResetDriveMode(portResetDriveMode),
   .extResetPinSelect(extResetPinSelect), .debugAccessEnable(debugAccessEnable),
   .bootClockSpeed(bootClockSpeed), .eccRegionEnable(eccRegionEnable),
   .configValid(configValid), .debugPortSelect(debugPortSelect),
   .digitalClockPhaseDelay(digitalClockPhaseDelay));
`default_nettype wire

// ==== sim/rcl_reset_config_latch_test.sv ====
// self-checking bench of the reset configuration latch array
`timescale 1ns/1ps
`default_nettype none
module rcl_reset_config_latch_test;
   logic        clk = 0, rstn = 0, regWrite = 0, regRead = 0, cv;
   logic [1:0]  regAddr = 2'h0;
   logic [7:0]  regWdata = 8'h00, regRdata, lf = 8'h0E;
   logic [7:0]  b [4];
   // several dut outputs drive slices of one vector, so it is a net
   wire logic [27:0] cfg;
   logic [27:0] e;
   int          errCount = 0, testsRun = 0, k, n;
   rcl_reset_config_latch dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .portResetDriveMode(cfg[27:10]), .extResetPinSelect(cfg[9]),
      .debugAccessEnable(cfg[8]), .debugPortSelect(cfg[7:6]), .bootClockSpeed(cfg[5]),
      .eccRegionEnable(cfg[4]), .digitalClockPhaseDelay(cfg[3:0]), .configValid(cv));
   // 8 ns clock
   initial forever #4 clk = ~clk;
   // lfsr step, fixed start keeps runs repeatable
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // expected settings from the four latch bytes
   function automatic logic [27:0] ex(input logic [7:0] b0, b1, b2, b3);
      return {b2[1:0], b1, b0, b2[7], b2[6], b3[2:1], b3[0], b3[3], b3[7:4]};
   endfunction
   task automatic finishTest;
      $display("checks %0d errors %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      testsRun++;
      if (ok !== 1'b1) begin
         errCount++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   // one bus cycle, launched just after the edge
   task automatic bus(input logic w, r, input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= w;
      regRead <= r;
      regAddr <= a;
      regWdata <= d;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] x);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      #1 chk(regRdata === x, "read data");
   endtask
   // reset pulse, then bounded wait for capture
   task automatic rst(input logic [27:0] x);
      @(posedge clk);
      rstn <= 0;
      repeat (3) @(posedge clk);
      #1 chk(cfg === 28'h000_0150 && cv === 1'b0 && regRdata === 8'h00, "factory");
      @(posedge clk);
      rstn <= 1;
      n = 0;
      while (cv !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1 n++;
      end
      // a hang counts twice, here and in the failed check below, and ends the pass loop, then the report runs
      if (n == 8) begin
         errCount++;
      end
      chk(n == 2 && cfg === x, "captured settings");
   endtask
   initial begin
      e = 28'h000_0150;
      rst(e);
      for (k = 0; k < 6 && n < 8; k++) begin
         // first four passes cover every drive and debug port code, then random
         for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            b[i] = (k < 4) ? {4{k[1:0]}} : lf;
            bus(1'b1, 1'b0, i[1:0], b[i]);
            rd(i[1:0], b[i] & (i == 2 ? 8'hC3 : 8'hFF));
         end
         // captured copy must still be the one from the last reset
         chk(cfg === e, "settings moved before reset");
         e = ex(b[0], b[1], b[2], b[3]);
         rst(e);
      end
      finishTest();
   end
endmodule
`default_nettype wire
